// >>> verilog/palette_dac_pkg.sv
// Package of addresses, reset values, carrier structs and state layout.
package palette_dac_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Host I/O addresses of the palette registers.
    localparam logic [15:0] ADDR_PIXEL_READ_MASK = 16'h03c6;
    localparam logic [15:0] ADDR_READ_INDEX_STATUS = 16'h03c7;
    localparam logic [15:0] ADDR_PALETTE_WRITE_INDEX = 16'h03c8;
    localparam logic [15:0] ADDR_PALETTE_DATA_PORT = 16'h03c9;

    ////////////////////////////////////////////////////////////////////////
    // Field layout and encodings.
    localparam int COMPONENT_BITS = 6;
    localparam logic [1:0] STATUS_WRITE = 2'h0;
    localparam logic [1:0] STATUS_READ = 2'h3;
    localparam logic [1:0] COMP_RED = 2'h0;
    localparam logic [1:0] COMP_GREEN = 2'h1;
    localparam logic [1:0] COMP_BLUE = 2'h2;
    localparam logic [1:0] RS_DATA_PORT = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Values after reset.
    localparam logic [7:0] MASK_RESET = 8'hff;
    localparam logic [7:0] INDEX_RESET = 8'h00;
    localparam logic [1:0] STATUS_RESET = STATUS_WRITE;
    localparam logic [1:0] COMP_RESET = COMP_RED;

    ////////////////////////////////////////////////////////////////////////
    // Types.
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_READ = 2'b01,
        SEQ_WRITE = 2'b10
    } seq_mode_t;

    typedef struct packed {
        logic [15:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } io_req_t;

    typedef struct packed {
        logic [1:0] rs;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } dac_bus_t;

    typedef struct packed {
        logic [7:0] mask;
        logic [7:0] rd_idx;
        logic [7:0] wr_idx;
        logic [1:0] comp;
        seq_mode_t mode;
        logic [1:0] status;
        logic [5:0] red;
        logic [5:0] green;
        logic [7:0] inport_ff1;
        logic [7:0] inport_ff2;
        logic [7:0] inport_ff3;
        logic [7:0] inport;
        logic [7:0] rdata;
        logic rvalid;
        dac_bus_t dac;
        logic commit;
        logic [7:0] commit_idx;
        logic [17:0] commit_data;
        logic [7:0] color_index;
    } dac_port_state_t;

endpackage : palette_dac_pkg

// >>> verilog/palette_dac_access_port.sv
// Host access port for the colour look-up table of an external video DAC.
`timescale 1ns/1ps

module palette_dac_access_port
    import palette_dac_pkg::*;
(
    // Clock and reset.
    input wire logic clock_i,
    input wire logic srst_i,
    // Host I/O cycles.
    input wire io_req_t io_req_i,
    output logic [7:0] io_rdata_o,
    output logic io_rvalid_o,
    // Controls from the extended registers.
    input wire logic dac_write_lock_i,
    input wire logic inport_read_enable_i,
    // External input buffer pins.
    input wire logic [7:0] general_input_port_i,
    // External video DAC.
    output dac_bus_t dac_o,
    input wire logic [7:0] dac_rdata_i,
    output logic entry_commit_o,
    output logic [7:0] entry_index_o,
    output logic [17:0] entry_data_o,
    // Pixel path.
    input wire logic [7:0] pixel_select_outputs_i,
    output logic [7:0] color_index_o
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode; the address check serves both paths, the register select only writes.

    function automatic logic is_dac_addr(input logic [15:0] addr);
        is_dac_addr = (addr == ADDR_PIXEL_READ_MASK) ||
                      (addr == ADDR_READ_INDEX_STATUS) ||
                      (addr == ADDR_PALETTE_WRITE_INDEX) ||
                      (addr == ADDR_PALETTE_DATA_PORT);
    endfunction : is_dac_addr

    function automatic logic [1:0] dac_rs(input logic [15:0] addr);
        dac_rs = 2'(addr[1:0] - 2'h2);
    endfunction : dac_rs

    ////////////////////////////////////////////////////////////////////////
    // State.

    dac_port_state_t st;
    dac_port_state_t next_st;
    logic [7:0] inport_diff;

    always_comb
    begin
        next_st = st;
        next_st.rvalid = 1'b0;
        next_st.commit = 1'b0;
        next_st.dac.rd = 1'b0;
        next_st.dac.wr = 1'b0;

        // Only the second and third stages feed the filter.
        next_st.inport_ff1 = general_input_port_i;
        next_st.inport_ff2 = st.inport_ff1;
        next_st.inport_ff3 = st.inport_ff2;
        inport_diff = st.inport_ff2 ^ st.inport_ff3;
        next_st.inport = (~inport_diff & st.inport_ff3) |
                         (inport_diff & st.inport);

        next_st.color_index = pixel_select_outputs_i & st.mask;

        // Writes are dropped whole while the lock is set.
        if (io_req_i.wr && !dac_write_lock_i && is_dac_addr(io_req_i.addr))
        begin
            next_st.dac.wr = 1'b1;
            next_st.dac.rs = dac_rs(io_req_i.addr);
            next_st.dac.wdata = io_req_i.wdata;
            case (io_req_i.addr)
                ADDR_PIXEL_READ_MASK:
                begin
                    next_st.mask = io_req_i.wdata;
                end
                ADDR_READ_INDEX_STATUS:
                begin
                    next_st.rd_idx = io_req_i.wdata;
                    next_st.mode = SEQ_READ;
                    next_st.status = STATUS_READ;
                    next_st.comp = COMP_RED;
                end
                ADDR_PALETTE_WRITE_INDEX:
                begin
                    next_st.wr_idx = io_req_i.wdata;
                    next_st.mode = SEQ_WRITE;
                    next_st.status = STATUS_WRITE;
                    next_st.comp = COMP_RED;
                end
                ADDR_PALETTE_DATA_PORT:
                begin
                    // A data write in a read sequence leaves it untouched.
                    if (st.mode == SEQ_WRITE)
                    begin
                        case (st.comp)
                            COMP_RED:
                            begin
                                next_st.red = io_req_i.wdata[5:0];
                                next_st.comp = COMP_GREEN;
                            end
                            COMP_GREEN:
                            begin
                                next_st.green = io_req_i.wdata[5:0];
                                next_st.comp = COMP_BLUE;
                            end
                            default:
                            begin
                                next_st.commit = 1'b1;
                                next_st.commit_idx = st.wr_idx;
                                next_st.commit_data = {st.red, st.green,
                                    io_req_i.wdata[5:0]};
                                next_st.wr_idx = 8'(st.wr_idx + 8'h01);
                                next_st.comp = COMP_RED;
                            end
                        endcase
                    end
                end
                default:
                begin
                    next_st.dac.wr = 1'b0;
                end
            endcase
        end

        if (io_req_i.rd && is_dac_addr(io_req_i.addr))
        begin
            next_st.rvalid = 1'b1;
            case (io_req_i.addr)
                ADDR_PIXEL_READ_MASK:
                begin
                    next_st.rdata = st.mask;
                end
                ADDR_READ_INDEX_STATUS:
                begin
                    next_st.rdata = {6'h00, st.status};
                end
                ADDR_PALETTE_WRITE_INDEX:
                begin
                    if (inport_read_enable_i)
                    begin
                        next_st.rdata = st.inport;
                    end
                    else
                    begin
                        next_st.rdata = st.wr_idx;
                    end
                end
                ADDR_PALETTE_DATA_PORT:
                begin
                    next_st.rdata = {2'h0,
                        dac_rdata_i[COMPONENT_BITS-1:0]};
                    next_st.dac.rd = 1'b1;
                    next_st.dac.rs = RS_DATA_PORT;
                    // A data read in a write sequence leaves it untouched.
                    if (st.mode == SEQ_READ)
                    begin
                        if (st.comp == COMP_BLUE)
                        begin
                            next_st.rd_idx = 8'(st.rd_idx + 8'h01);
                            next_st.comp = COMP_RED;
                        end
                        else
                        begin
                            next_st.comp = 2'(st.comp + 2'h1);
                        end
                    end
                end
                default:
                begin
                    next_st.rvalid = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            st <= '0;
            st.mask <= MASK_RESET;
            st.rd_idx <= INDEX_RESET;
            st.wr_idx <= INDEX_RESET;
            st.comp <= COMP_RESET;
            st.mode <= SEQ_IDLE;
            st.status <= STATUS_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register.

    assign io_rdata_o = st.rdata;
    assign io_rvalid_o = st.rvalid;
    assign dac_o = st.dac;
    assign entry_commit_o = st.commit;
    assign entry_index_o = st.commit_idx;
    assign entry_data_o = st.commit_data;
    assign color_index_o = st.color_index;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);

    logic wr_ok;
    logic rd_data;
    assign wr_ok = io_req_i.wr && !dac_write_lock_i;
    assign rd_data = io_req_i.rd && io_req_i.addr == ADDR_PALETTE_DATA_PORT;

    AST_MASK_GATES_PIXEL: assert property (
        ##1 color_index_o ==
            ($past(pixel_select_outputs_i) & $past(st.mask)))
        else $error("Colour index is not the masked pixel value.");

    AST_MASK_WRITE_READ: assert property (
        wr_ok && io_req_i.addr == ADDR_PIXEL_READ_MASK ##1
        io_req_i.rd && io_req_i.addr == ADDR_PIXEL_READ_MASK &&
        !io_req_i.wr
        |=> io_rvalid_o && io_rdata_o == $past(io_req_i.wdata, 2))
        else $error("Pixel read mask did not read back its value.");

    AST_READ_INDEX_STARTS: assert property (
        wr_ok && io_req_i.addr == ADDR_READ_INDEX_STATUS
        |=> st.mode == SEQ_READ && st.comp == COMP_RED &&
            st.rd_idx == $past(io_req_i.wdata))
        else $error("Read index write did not start a read sequence.");

    AST_READ_BYTE_FORMAT: assert property (
        rd_data |=> io_rvalid_o && io_rdata_o[7:6] == 2'h0 &&
            io_rdata_o[5:0] == $past(dac_rdata_i[5:0]))
        else $error("Read byte does not carry a six-bit component.");

    AST_READ_INDEX_ADVANCES: assert property (
        rd_data && !io_req_i.wr && st.mode == SEQ_READ &&
        st.comp == COMP_BLUE
        |=> st.rd_idx == 8'($past(st.rd_idx) + 8'h01) &&
            st.comp == COMP_RED)
        else $error("Read index did not advance after the third byte.");

    AST_INDEX_RESTARTS: assert property (
        wr_ok && (io_req_i.addr == ADDR_READ_INDEX_STATUS ||
            io_req_i.addr == ADDR_PALETTE_WRITE_INDEX)
        |=> st.comp == COMP_RED && !entry_commit_o)
        else $error("Index write did not restart the sequence.");

    AST_STATUS_VALUE: assert property (
        io_req_i.rd && io_req_i.addr == ADDR_READ_INDEX_STATUS
        |=> io_rdata_o == {6'h00, $past(st.status)} &&
            (io_rdata_o[1:0] == STATUS_READ ||
             io_rdata_o[1:0] == STATUS_WRITE))
        else $error("Status read gave a wrong value.");

    AST_READS_LEAVE_SEQ: assert property (
        io_req_i.rd && !io_req_i.wr &&
        (io_req_i.addr == ADDR_READ_INDEX_STATUS ||
         io_req_i.addr == ADDR_PALETTE_WRITE_INDEX)
        |=> $stable(st.comp) && $stable(st.mode))
        else $error("Index or status read disturbed a sequence.");

    AST_WRITE_TRIPLE_STORED: assert property (
        wr_ok && io_req_i.addr == ADDR_PALETTE_DATA_PORT &&
        st.mode == SEQ_WRITE && st.comp == COMP_BLUE
        |=> entry_commit_o && entry_index_o == $past(st.wr_idx) &&
            entry_data_o == {$past(st.red), $past(st.green),
                $past(io_req_i.wdata[5:0])} &&
            st.wr_idx == 8'($past(st.wr_idx) + 8'h01))
        else $error("Write triple was not stored at the write index.");

    AST_INPORT_READ: assert property (
        io_req_i.rd && io_req_i.addr == ADDR_PALETTE_WRITE_INDEX &&
        inport_read_enable_i
        |=> io_rdata_o == $past(st.inport))
        else $error("Input port data did not appear on index read.");

    AST_WRITE_STEERED: assert property (
        wr_ok && io_req_i.addr == ADDR_PALETTE_DATA_PORT
        |=> dac_o.wr && dac_o.rs == RS_DATA_PORT &&
            dac_o.wdata == $past(io_req_i.wdata))
        else $error("Data write was not steered to the DAC.");

    AST_LOCK_BLOCKS: assert property (
        io_req_i.wr && dac_write_lock_i
        |=> !dac_o.wr && !entry_commit_o && $stable(st.mask) &&
            $stable(st.rd_idx) && $stable(st.wr_idx))
        else $error("A locked write reached the DAC registers.");

    AST_NO_ANSWER_OUTSIDE: assert property (
        io_req_i.rd && !is_dac_addr(io_req_i.addr)
        |=> !io_rvalid_o)
        else $error("A read outside the palette addresses was answered.");

    AST_DATA_READ_STEERED: assert property (
        rd_data
        |=> dac_o.rd && dac_o.rs == RS_DATA_PORT)
        else $error("Data read was not steered to the DAC.");

    AST_COMMIT_AFTER_BLUE: assert property (
        entry_commit_o
        |-> $past(wr_ok && io_req_i.addr == ADDR_PALETTE_DATA_PORT &&
            st.mode == SEQ_WRITE && st.comp == COMP_BLUE))
        else $error("An entry was stored without a blue byte.");

    AST_WRITE_INDEX_STATUS: assert property (
        wr_ok && io_req_i.addr == ADDR_PALETTE_WRITE_INDEX
        |=> st.status == STATUS_WRITE && st.mode == SEQ_WRITE &&
            st.wr_idx == $past(io_req_i.wdata))
        else $error("Write index write did not start a write sequence.");

    // A bit may only follow the pin once stages two and three agreed,
    // so a one-cycle glitch on the pin never reaches a read.
    AST_INPORT_FILTERED: assert property (
        !$stable(st.inport)
        |-> ((st.inport ^ $past(st.inport)) &
            ($past(st.inport_ff2) ^ $past(st.inport_ff3))) == 8'h00)
        else $error("Input port bit changed before two stages agreed.");

endmodule : palette_dac_access_port

// >>> verif/dac_model.sv
// Behavioural model of the external video DAC and its colour table.
`timescale 1ns/1ps

module dac_model
    import palette_dac_pkg::*;
(
    // Clock.
    input wire logic clock_i,
    // Steered DAC bus.
    input wire dac_bus_t dac_i,
    output logic [7:0] rdata_o
);
    logic [17:0] table_q [256];
    logic [7:0] ridx;
    logic [7:0] widx;
    logic [1:0] comp = 2'h0;
    logic rmode = 1'b0;
    logic [11:0] part;
    logic [17:0] cur;

    ////////////////////////////////////////////////////////////////////////
    // Top bits come back set in read mode, so the port itself must clear them.
    assign cur = table_q[ridx];
    assign rdata_o = rmode ? {2'b11, cur[17 - 6 * comp -: 6]} : 8'h5a;

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clock_i)
    begin
        if (dac_i.wr && dac_i.rs == 2'h1)
        begin
            ridx <= dac_i.wdata;
            comp <= 2'h0;
            rmode <= 1'b1;
        end
        else if (dac_i.wr && dac_i.rs == 2'h2)
        begin
            widx <= dac_i.wdata;
            comp <= 2'h0;
            rmode <= 1'b0;
        end
        else if (dac_i.wr && dac_i.rs == 2'h3 && !rmode)
        begin
            if (comp == 2'h2)
            begin
                table_q[widx] <= {part, dac_i.wdata[5:0]};
                widx <= widx + 8'h01;
                comp <= 2'h0;
            end
            else
            begin
                part <= {part[5:0], dac_i.wdata[5:0]};
                comp <= comp + 2'h1;
            end
        end
        else if (dac_i.rd && dac_i.rs == 2'h3 && rmode)
        begin
            ridx <= (comp == 2'h2) ? ridx + 8'h01 : ridx;
            comp <= (comp == 2'h2) ? 2'h0 : comp + 2'h1;
        end
    end

endmodule : dac_model

// >>> verif/testbench.sv
// Self-checking bench for the palette access port with a DAC model.
`timescale 1ns/1ps

module testbench
    import palette_dac_pkg::*;
;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    io_req_t io_req = '0;
    logic lock = 1'b0;
    logic inport_en = 1'b0;
    logic [7:0] port_pins = 8'h00;
    logic [7:0] pixel = 8'h00;
    logic [7:0] io_rdata;
    logic io_rvalid;
    dac_bus_t dac;
    logic [7:0] dac_rdata;
    logic commit;
    logic [7:0] commit_idx;
    logic [17:0] commit_data;
    logic [7:0] color_index;
    logic [7:0] rd_exp [$];
    logic [25:0] entry_exp [$];
    logic [17:0] shadow [256];
    logic [31:0] seed = 32'd25;
    logic [7:0] mask_val;
    int miscompares = 0;
    int cmp_count = 0;

    always #2 clock_i = ~clock_i;

    palette_dac_access_port uut (
        .clock_i(clock_i), .srst_i(srst_i), .io_req_i(io_req),
        .io_rdata_o(io_rdata), .io_rvalid_o(io_rvalid),
        .dac_write_lock_i(lock), .inport_read_enable_i(inport_en),
        .general_input_port_i(port_pins), .dac_o(dac),
        .dac_rdata_i(dac_rdata),
        .entry_commit_o(commit), .entry_index_o(commit_idx),
        .entry_data_o(commit_data), .pixel_select_outputs_i(pixel),
        .color_index_o(color_index));

    dac_model dac_far (.clock_i(clock_i), .dac_i(dac), .rdata_o(dac_rdata));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xorshift

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_byte

    task automatic check_entry(input logic [25:0] got, input logic [25:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_entry

    // One host cycle, with an idle cycle after it for the DAC to follow.
    task automatic io(input logic [15:0] a, input logic r, input logic [7:0] d);
        @(posedge clock_i);
        io_req <= {a, r, !r, d};
        @(posedge clock_i);
        io_req <= {a, 1'b0, 1'b0, d};
    endtask : io

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        rd_exp.push_back(e);
        io(a, 1'b1, 8'h00);
    endtask : rd

    task automatic put_entry(input logic [7:0] idx, input logic [17:0] v,
                             input logic keep);
        if (keep)
        begin
            shadow[idx] = v;
            entry_exp.push_back({idx, v});
        end
        for (int c = 0; c < 3; c++)
            io(ADDR_PALETTE_DATA_PORT, 1'b0, {2'b10, v[17 - 6 * c -: 6]});
    endtask : put_entry

    task automatic get_comp(input logic [7:0] idx, input int c);
        rd(ADDR_PALETTE_DATA_PORT, {2'b00, shadow[idx][17 - 6 * c -: 6]});
    endtask : get_comp

    task automatic results();
        if (rd_exp.size() != 0 || entry_exp.size() != 0)
            miscompares++;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////
    // An answer with no note behind it is an error as well.
    always @(negedge clock_i)
    begin
        if (io_rvalid === 1'b1 && rd_exp.size() == 0)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, io_rdata, 8'h00);
        end
        else if (io_rvalid === 1'b1)
            check_byte(io_rdata, rd_exp.pop_front());
        if (commit === 1'b1 && entry_exp.size() == 0)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, commit_idx, 8'h00);
        end
        else if (commit === 1'b1)
            check_entry({commit_idx, commit_data},
                entry_exp.pop_front());
    end

    initial
    begin
        repeat (5000) @(posedge clock_i);
        miscompares++;
        results();
    end

    ////////////////////////////////////////////////////////////////////////
    // Data port traffic never crosses sequence kinds here.
    initial
    begin
        repeat (4) @(posedge clock_i);
        srst_i <= 1'b0;
        rd(ADDR_READ_INDEX_STATUS, {6'h00, STATUS_RESET});
        rd(ADDR_PIXEL_READ_MASK, MASK_RESET);
        mask_val = 8'(xorshift());
        // Write and read back to back, with no idle cycle between them.
        rd_exp.push_back(mask_val);
        @(posedge clock_i);
        io_req <= {ADDR_PIXEL_READ_MASK, 1'b0, 1'b1, mask_val};
        io(ADDR_PIXEL_READ_MASK, 1'b1, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clock_i);
            pixel <= 8'(xorshift());
            repeat (2) @(posedge clock_i);
            @(negedge clock_i);
            check_byte(color_index, pixel & mask_val);
        end
        $display("test mask done");
        io(ADDR_PALETTE_WRITE_INDEX, 1'b0, 8'hfe);
        for (int e = 0; e < 3; e++)
            put_entry(8'(8'hfe + e), 18'(xorshift()), 1'b1);
        rd(ADDR_PALETTE_WRITE_INDEX, 8'h01);
        rd(ADDR_READ_INDEX_STATUS, {6'h00, STATUS_WRITE});
        $display("test write done");
        io(ADDR_READ_INDEX_STATUS, 1'b0, 8'hfe);
        for (int c = 0; c < 3; c++)
            get_comp(8'hfe, c);
        get_comp(8'hff, 0);
        rd(ADDR_READ_INDEX_STATUS, {6'h00, STATUS_READ});
        rd(ADDR_PALETTE_WRITE_INDEX, 8'h01);
        get_comp(8'hff, 1);
        get_comp(8'hff, 2);
        for (int c = 0; c < 3; c++)
            get_comp(8'h00, c);
        $display("test read done");
        io(ADDR_READ_INDEX_STATUS, 1'b0, 8'hfe);
        get_comp(8'hfe, 0);
        io(ADDR_READ_INDEX_STATUS, 1'b0, 8'hff);
        get_comp(8'hff, 0);
        io(ADDR_PALETTE_WRITE_INDEX, 1'b0, 8'h10);
        io(ADDR_PALETTE_DATA_PORT, 1'b0, 8'h3f);
        io(ADDR_PALETTE_DATA_PORT, 1'b0, 8'h3f);
        io(ADDR_PALETTE_WRITE_INDEX, 1'b0, 8'h10);
        put_entry(8'h10, 18'(xorshift()), 1'b1);
        io(ADDR_READ_INDEX_STATUS, 1'b0, 8'h10);
        for (int c = 0; c < 3; c++)
            get_comp(8'h10, c);
        $display("test abort done");
        @(posedge clock_i);
        lock <= 1'b1;
        io(ADDR_PALETTE_WRITE_INDEX, 1'b0, 8'h20);
        put_entry(8'h20, 18'(xorshift()), 1'b0);
        io(ADDR_PIXEL_READ_MASK, 1'b0, ~mask_val);
        lock <= 1'b0;
        rd(ADDR_PIXEL_READ_MASK, mask_val);
        rd(ADDR_PALETTE_WRITE_INDEX, 8'h11);
        io(16'h03c5, 1'b1, 8'h00);
        io(16'h03ca, 1'b1, 8'h00);
        $display("test lock done");
        @(posedge clock_i);
        inport_en <= 1'b1;
        port_pins <= 8'(xorshift());
        repeat (6) @(posedge clock_i);
        rd(ADDR_PALETTE_WRITE_INDEX, port_pins);
        inport_en <= 1'b0;
        rd(ADDR_PALETTE_WRITE_INDEX, 8'h11);
        $display("test input port done");
        repeat (4) @(posedge clock_i);
        results();
    end

endmodule : testbench
